//--- rtl/led_group_select_brightness_monitor.sv
// Design decisions made here: the address map and register access over Avalon-MM.
`timescale 1ns/1ns
`include "lgs_consts.svh"

// Contract
// R01: code zero: driver off, shunt high, colors low
// R02: low bits zero: blanking for high-bit color
// R03: low bits nonzero: driver on, group, color
// R04: four threshold sets, current group applied
// R05: per group per color threshold entries
// R06: big capacitor select output provided
// R07: big capacitor only in discontinuous mode
// R08: compare output falls when threshold reached
// R09: flag secondary amp above excess threshold
// R10: excess source high or low bandwidth
// R11: software retunes excess threshold with dimming
// R12: adjustable primary amplifier gain setting
// R13: request fall: shunt low, driver on-off-on
// R14: threshold crossed: shunt high ends pulse
// R15: per-color pulse width limit ends pulse
// R16: registered decode, disabled after reset
module led_group_select_brightness_monitor #(
    parameter int AMP_W = 10,
    parameter int PW_W  = 16
) (
    input  wire logic               SYS_CLK,
    input  wire logic               ARST_N,
    input  wire logic [`ADDR_W-1:0] AVS_ADDRESS,
    input  wire logic               AVS_READ,
    input  wire logic               AVS_WRITE,
    input  wire logic [31:0]        AVS_WRITEDATA,
    input  wire logic [3:0]         AVS_BYTEENABLE,
    output logic      [31:0]        AVS_READDATA,
    output logic                    AVS_WAITREQUEST,
    input  wire logic [3:0]         LED_SELECT_CODE,
    input  wire logic               PULSE_ENABLE,
    input  wire logic               SHUNT_REQUEST,
    input  wire logic               PHOTO_REACHED,
    input  wire logic [AMP_W-1:0]   SEC_AMP_HB,
    input  wire logic [AMP_W-1:0]   SEC_AMP_LB,
    output logic                    DRIVER_ENABLE_OUT,
    output logic                    SHUNT_ENABLE_OUT,
    output logic [2:0]              COLOR_SELECT,
    output logic                    BLANK_SELECT,
    output logic                    BIG_CAP_SELECT,
    output logic                    PHOTO_COMPARE_OUT,
    output logic [AMP_W-1:0]        PHOTO_THRESHOLD,
    output logic [2:0]              PRIMARY_AMP_GAIN,
    output logic                    EXCESS_BRIGHT,
    output logic                    IRQ
);

    localparam int TOGGLE_CYC =
        (`TOGGLE_NS + `CLK_NS - 1) / `CLK_NS < 1 ? 1 :
        (`TOGGLE_NS + `CLK_NS - 1) / `CLK_NS;
    localparam logic [7:0] TOGGLE_LAST = 8'(TOGGLE_CYC - 1);

    // ==========================================================
    // led select decode
    function automatic lgs_pkg::led_decode_t decode(input logic [3:0] c);
        lgs_pkg::led_decode_t d;
        d = '0;
        if (c[1:0] == `SEL_OFF) begin
            // R02: blanking color from high bits
            d.blank = (c[3:2] != `SEL_OFF);
            d.color = c[3:2];
        end else begin
            // R03: group from high, color from low bits
            d.driver_enable_out = 1'b1;
            d.group  = c[3:2];
            d.color  = c[1:0];
        end
        return d;
    endfunction

    lgs_pkg::led_decode_t dec_r;

    // R16: registered decode
    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            dec_r <= '0;
        end else begin
            dec_r <= decode(LED_SELECT_CODE);
        end
    end

    // ==========================================================
    // bus slave: two wait cycles, answer on the third edge
    logic [1:0]  phase_r;
    logic        req;
    logic        wr_fire;
    logic        is_tbl;
    logic [31:0] bemask;
    logic [31:0] rdata_r;
    logic [31:0] rmux;

    assign req     = AVS_READ | AVS_WRITE;
    assign wr_fire = AVS_WRITE && phase_r == 2'h2;
    assign is_tbl  = AVS_ADDRESS[`TABLE_SEL_BIT];
    assign AVS_WAITREQUEST = req && phase_r != 2'h2;
    assign AVS_READDATA    = rdata_r;

    always_comb begin
        for (int i = 0; i < 4; i++) begin
            bemask[i*8 +: 8] = {8{AVS_BYTEENABLE[i]}};
        end
    end

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] wd,
                                          input logic [31:0] m);
        return (old & ~m) | (wd & m);
    endfunction

    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            phase_r <= 2'h0;
        end else if (req && phase_r != 2'h2) begin
            phase_r <= phase_r + 2'h1;
        end else begin
            phase_r <= 2'h0;
        end
    end

    // ==========================================================
    // registers
    lgs_pkg::ctrl_t          ctrl_r;
    logic [`ST_W-1:0]        status_r;
    logic [`ST_W-1:0]        irq_en_r;
    logic [`ST_W-1:0]        st_set;
    logic [AMP_W-1:0]        exc_thr_r;
    logic [PW_W-1:0]         pw_lim_r [3];
    logic [AMP_W-1:0]        tbl_rd_b;
    logic [31:0]             ctrl_word;
    logic [31:0]             live_word;
    logic [31:0]             ctrl_m;
    lgs_pkg::pulse_state_t   st_r;
    logic                    shunt_r;
    logic                    drv_r;

    assign ctrl_word = {25'h0, ctrl_r.gain, ctrl_r.exc_lb, ctrl_r.exc_en,
                        ctrl_r.bigcap, ctrl_r.disc};
    assign live_word = {20'h0, 2'(st_r), shunt_r, drv_r,
                        dec_r.driver_enable_out, dec_r.blank, dec_r.group,
                        dec_r.color, 2'h0};
    assign ctrl_m    = merge(ctrl_word, AVS_WRITEDATA, bemask);

    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            ctrl_r <= lgs_pkg::ctrl_t'(7'(`CTRL_RESET));
        end else if (wr_fire && AVS_ADDRESS == `OFS_CTRL) begin
            // field by field: the struct packs disc at its top bit
            ctrl_r <= '{disc:   ctrl_m[`CTRL_DISC],
                        bigcap: ctrl_m[`CTRL_BIGCAP],
                        exc_en: ctrl_m[`CTRL_EXC_EN],
                        exc_lb: ctrl_m[`CTRL_EXC_LB],
                        gain:   ctrl_m[`CTRL_GAIN_HI:`CTRL_GAIN_LO]};
        end
    end

    // R12: primary amplifier gain
    assign PRIMARY_AMP_GAIN = ctrl_r.gain;

    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            irq_en_r <= '0;
        end else if (wr_fire && AVS_ADDRESS == `OFS_IRQ_EN) begin
            irq_en_r <= `ST_W'(merge(32'(irq_en_r), AVS_WRITEDATA, bemask));
        end
    end

    // R11: threshold is software's to retune
    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            exc_thr_r <= `EXC_THR_RESET;
        end else if (wr_fire && AVS_ADDRESS == `OFS_EXCESS_THR) begin
            exc_thr_r <= AMP_W'(merge(32'(exc_thr_r), AVS_WRITEDATA, bemask));
        end
    end

    // R15: one pulse width limit per color
    for (genvar g = 0; g < 3; g++) begin : g_pwlim
        localparam logic [`ADDR_W-1:0] OFS =
            `ADDR_W'(`OFS_PW_LIM_RED + 4 * g);
        always_ff @(posedge SYS_CLK or negedge ARST_N) begin
            if (!ARST_N) begin
                pw_lim_r[g] <= `PW_LIM_RESET;
            end else if (wr_fire && AVS_ADDRESS == OFS) begin
                pw_lim_r[g] <= PW_W'(merge(32'(pw_lim_r[g]),
                                           AVS_WRITEDATA, bemask));
            end
        end
    end

    // sticky status; a set in the clearing cycle survives
    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            status_r <= '0;
        end else if (wr_fire && AVS_ADDRESS == `OFS_IRQ_CLR) begin
            status_r <= status_r & ~(AVS_WRITEDATA[`ST_W-1:0]
                         & {`ST_W{AVS_BYTEENABLE[0]}}) | st_set;
        end else begin
            status_r <= status_r | st_set;
        end
    end

    assign IRQ = |(status_r & irq_en_r);

    always_comb begin
        rmux = 32'h0;
        if (is_tbl) begin
            rmux = 32'(tbl_rd_b);
        end else begin
            unique case (AVS_ADDRESS)
                `OFS_CTRL:       rmux = ctrl_word;
                `OFS_STATUS:     rmux = 32'(status_r);
                `OFS_IRQ_EN:     rmux = 32'(irq_en_r);
                `OFS_EXCESS_THR: rmux = 32'(exc_thr_r);
                `OFS_LIVE:       rmux = live_word;
                `OFS_PW_LIM_RED: rmux = 32'(pw_lim_r[0]);
                `OFS_PW_LIM_GRN: rmux = 32'(pw_lim_r[1]);
                `OFS_PW_LIM_BLU: rmux = 32'(pw_lim_r[2]);
                default:         rmux = 32'h0;
            endcase
        end
    end

    // memory read data is ready after the first edge
    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            rdata_r <= 32'h0;
        end else if (AVS_READ && phase_r == 2'h1) begin
            rdata_r <= rmux;
        end
    end

    // ==========================================================
    // R04: threshold table indexed by group and color
    logic [AMP_W-1:0] tbl_rd_a;

    // R05: each group holds its own per-color entry
    thr_table #(
        .DATA_W (AMP_W),
        .ADDR_W (4)
    ) u_thr_table (
        .clk       (SYS_CLK),
        .wr_en     (wr_fire && is_tbl),
        .wr_addr   (AVS_ADDRESS[5:2]),
        .wr_data   (AMP_W'(merge(32'(tbl_rd_b), AVS_WRITEDATA, bemask))),
        .rd_a_addr ({dec_r.group, dec_r.color}),
        .rd_a_data (tbl_rd_a),
        .rd_b_addr (AVS_ADDRESS[5:2]),
        .rd_b_data (tbl_rd_b)
    );

    assign PHOTO_THRESHOLD = tbl_rd_a;

    // ==========================================================
    // discontinuous pulse sequencing
    lgs_pkg::pulse_state_t st_nxt;
    logic                  req_prev_r;
    logic                  req_fall;
    logic                  pulse_ok;
    logic [7:0]            tog_cnt_r;
    logic [PW_W-1:0]       pw_cnt_r;
    logic [PW_W-1:0]       pw_lim;
    logic                  reached;
    logic                  timeout;

    assign pulse_ok = ctrl_r.disc && dec_r.driver_enable_out && PULSE_ENABLE;
    assign req_fall = req_prev_r && !SHUNT_REQUEST;
    assign pw_lim   = (dec_r.color == `SEL_OFF) ? pw_lim_r[0]
                    : pw_lim_r[dec_r.color - 2'h1];
    assign reached  = st_r == lgs_pkg::PS_LIGHT && PHOTO_REACHED;
    assign timeout  = st_r == lgs_pkg::PS_LIGHT && !PHOTO_REACHED
                      && pw_cnt_r >= pw_lim;

    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            req_prev_r <= 1'b1;
        end else begin
            req_prev_r <= SHUNT_REQUEST;
        end
    end

    always_comb begin
        st_nxt = st_r;
        unique case (st_r)
            lgs_pkg::PS_IDLE: begin
                // R13: request fall starts the toggle
                if (pulse_ok && req_fall) begin
                    st_nxt = lgs_pkg::PS_DRV_OFF;
                end
            end
            lgs_pkg::PS_DRV_OFF: begin
                if (tog_cnt_r == TOGGLE_LAST) begin
                    st_nxt = lgs_pkg::PS_LIGHT;
                end
            end
            lgs_pkg::PS_LIGHT: begin
                // R14: threshold crossing ends the pulse
                // R15: width limit also ends it
                if (reached || timeout) begin
                    st_nxt = lgs_pkg::PS_IDLE;
                end
            end
        endcase
        if (!pulse_ok) begin
            st_nxt = lgs_pkg::PS_IDLE;
        end
    end

    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            st_r <= lgs_pkg::PS_IDLE;
        end else begin
            st_r <= st_nxt;
        end
    end

    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            tog_cnt_r <= 8'h0;
        end else if (st_r == lgs_pkg::PS_DRV_OFF) begin
            tog_cnt_r <= tog_cnt_r + 8'h1;
        end else begin
            tog_cnt_r <= 8'h0;
        end
    end

    // counts led-on time; saturates so a stuck pulse still times out
    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            pw_cnt_r <= '0;
        end else if (st_r == lgs_pkg::PS_LIGHT) begin
            if (pw_cnt_r != '1) begin
                pw_cnt_r <= pw_cnt_r + PW_W'(1);
            end
        end else begin
            pw_cnt_r <= '0;
        end
    end

    // ==========================================================
    // outputs
    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            shunt_r <= 1'b1;
        end else if (!dec_r.driver_enable_out) begin
            // R01: shunt held high when disabled
            shunt_r <= 1'b1;
        end else if (!ctrl_r.disc) begin
            shunt_r <= SHUNT_REQUEST;
        end else begin
            // R13: shunt low through toggle and light
            shunt_r <= st_nxt == lgs_pkg::PS_IDLE;
        end
    end

    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            drv_r <= 1'b0;
        end else begin
            // R01: no drive unless enabled mode
            // R13: off phase between two on phases
            drv_r <= dec_r.driver_enable_out && (!ctrl_r.disc || PULSE_ENABLE)
                     && st_nxt != lgs_pkg::PS_DRV_OFF;
        end
    end

    assign SHUNT_ENABLE_OUT  = shunt_r;
    assign DRIVER_ENABLE_OUT = drv_r;

    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            COLOR_SELECT <= 3'h0;
            BLANK_SELECT <= 1'b0;
        end else begin
            // R01: all colors low when the code is zero
            for (int i = 0; i < 3; i++) begin
                COLOR_SELECT[i] <= dec_r.color == 2'(i + 1);
            end
            BLANK_SELECT <= dec_r.blank;
        end
    end

    // R06: big capacitor select
    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            BIG_CAP_SELECT <= 1'b0;
        end else begin
            // R07: never in continuous operation
            BIG_CAP_SELECT <= ctrl_r.bigcap && ctrl_r.disc
                              && dec_r.driver_enable_out;
        end
    end

    // R08: falls on threshold, rises on next request
    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            PHOTO_COMPARE_OUT <= 1'b1;
        end else if (reached) begin
            PHOTO_COMPARE_OUT <= 1'b0;
        end else if (req_fall || !pulse_ok) begin
            PHOTO_COMPARE_OUT <= 1'b1;
        end
    end

    // ==========================================================
    // excess brightness monitor
    logic [AMP_W-1:0] exc_src;
    logic             exc_hit;

    // R10: bandwidth source choice
    assign exc_src = ctrl_r.exc_lb ? SEC_AMP_LB : SEC_AMP_HB;
    // R09: compare against threshold
    assign exc_hit = ctrl_r.exc_en && exc_src > exc_thr_r;

    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            EXCESS_BRIGHT <= 1'b0;
        end else begin
            EXCESS_BRIGHT <= exc_hit;
        end
    end

    always_comb begin
        st_set = '0;
        st_set[`ST_EXCESS]     = exc_hit;
        st_set[`ST_PULSE_DONE] = reached;
        st_set[`ST_TIMEOUT]    = timeout;
    end

endmodule

//--- rtl/lgs_consts.svh
`ifndef LGS_CONSTS_SVH
`define LGS_CONSTS_SVH

// ==========================================================
// register byte offsets
`define ADDR_W          7
`define OFS_CTRL        7'h00
`define OFS_STATUS      7'h04
`define OFS_IRQ_CLR     7'h08
`define OFS_IRQ_EN      7'h0C
`define OFS_EXCESS_THR  7'h10
`define OFS_LIVE        7'h14
`define OFS_PW_LIM_RED  7'h18
`define OFS_PW_LIM_GRN  7'h1C
`define OFS_PW_LIM_BLU  7'h20
`define OFS_TABLE_BASE  7'h40
`define TABLE_SEL_BIT   6

// ==========================================================
// control fields
`define CTRL_DISC       0
`define CTRL_BIGCAP     1
`define CTRL_EXC_EN     2
`define CTRL_EXC_LB     3
`define CTRL_GAIN_LO    4
`define CTRL_GAIN_HI    6
`define CTRL_RESET      32'h0000_0000

// status / interrupt fields
`define ST_EXCESS       0
`define ST_PULSE_DONE   1
`define ST_TIMEOUT      2
`define ST_W            3

// reset values
`define EXC_THR_RESET   10'h3FF
`define PW_LIM_RESET    16'h0100

// led select code values
`define SEL_OFF         2'h0
`define COL_RED         2'h1
`define COL_GRN         2'h2
`define COL_BLU         2'h3

// timing: width of the driver off pulse
`define TOGGLE_NS       20
`define CLK_NS          10

`endif

//--- rtl/lgs_pkg.sv
package lgs_pkg;

    typedef struct packed {
        logic       driver_enable_out;
        logic       blank;
        logic [1:0] group;
        logic [1:0] color;
    } led_decode_t;

    typedef struct packed {
        logic       disc;
        logic       bigcap;
        logic       exc_en;
        logic       exc_lb;
        logic [2:0] gain;
    } ctrl_t;

    typedef enum logic [1:0] {
        PS_IDLE,
        PS_DRV_OFF,
        PS_LIGHT
    } pulse_state_t;

endpackage

//--- rtl/thr_table.sv
`timescale 1ns/1ns

module thr_table #(
    parameter int DATA_W = 10,
    parameter int ADDR_W = 4
) (
    input  wire logic              clk,
    input  wire logic              wr_en,
    input  wire logic [ADDR_W-1:0] wr_addr,
    input  wire logic [DATA_W-1:0] wr_data,
    input  wire logic [ADDR_W-1:0] rd_a_addr,
    output logic      [DATA_W-1:0] rd_a_data,
    input  wire logic [ADDR_W-1:0] rd_b_addr,
    output logic      [DATA_W-1:0] rd_b_data
);

    logic [DATA_W-1:0] mem [2**ADDR_W];

    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    // registered reads; port a feeds the pulse path, b the bus
    always_ff @(posedge clk) begin
        rd_a_data <= mem[rd_a_addr];
        rd_b_data <= mem[rd_b_addr];
    end

endmodule

//--- verif/ctrl_model.sv
`timescale 1ns/1ns
// ============================================================
// display controller end of the pulse link
module ctrl_model (
    input  wire logic clk,
    input  wire logic drv,
    input  wire logic shunt,
    output logic      req,
    output logic      reached
);
    initial begin
        req     = 1'b1;
        reached = 1'b0;
    end

    // d is the answer delay in light cycles; a huge d never answers
    task automatic pulse(input int d, output int lit);
        int n;
        lit = 0;
        n   = 0;
        req <= 1'b0;
        @(posedge clk);
        while (!(drv && !shunt) && n < 20) begin
            n++;
            @(posedge clk);
        end
        while (!shunt && lit < 600) begin
            if (lit == d)
                reached <= 1'b1;
            lit++;
            @(posedge clk);
        end
        reached <= 1'b0;
        req     <= 1'b1;
    endtask
endmodule

//--- verif/lgs_checker.sv
`timescale 1ns/1ns
// ============================================================
// port checker
module lgs_checker #(
    parameter int AMP_W = 10
) (
    input wire logic             SYS_CLK,
    input wire logic             ARST_N,
    input wire logic [3:0]       LED_SELECT_CODE,
    input wire logic             PULSE_ENABLE,
    input wire logic             PHOTO_REACHED,
    input wire logic [AMP_W-1:0] SEC_AMP_HB,
    input wire logic [AMP_W-1:0] SEC_AMP_LB,
    input wire logic             DRIVER_ENABLE_OUT,
    input wire logic             SHUNT_ENABLE_OUT,
    input wire logic [2:0]       COLOR_SELECT,
    input wire logic             BLANK_SELECT,
    input wire logic             BIG_CAP_SELECT,
    input wire logic             PHOTO_COMPARE_OUT,
    input wire logic             EXCESS_BRIGHT
);
    logic [3:0] cd1_r;
    logic [3:0] cd2_r;
    logic       drv_code;
    logic       steady;

    // outputs lag the code by two edges
    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            cd1_r <= 4'h0;
            cd2_r <= 4'h0;
        end else begin
            cd1_r <= LED_SELECT_CODE;
            cd2_r <= cd1_r;
        end
    end
    assign drv_code = (cd2_r[1:0] != 2'h0);
    assign steady   = (cd2_r == cd1_r) && (cd1_r == LED_SELECT_CODE);

    function automatic logic [2:0] hot(input logic [3:0] c);
        logic [1:0] k;
        k = (c[1:0] != 2'h0) ? c[1:0] : c[3:2];
        hot = (k == 2'h0) ? 3'h0 : 3'h1 << (k - 2'h1);
    endfunction

    // ============================================================
    // assertions
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (!ARST_N);

    sequence s_drv_fall;
        $fell(DRIVER_ENABLE_OUT) && drv_code && steady && PULSE_ENABLE;
    endsequence
    sequence s_toggle;
        !SHUNT_ENABLE_OUT ##1 !DRIVER_ENABLE_OUT ##1 DRIVER_ENABLE_OUT;
    endsequence
    sequence s_lit_reach;
        DRIVER_ENABLE_OUT && !SHUNT_ENABLE_OUT && PHOTO_REACHED && steady
            && PULSE_ENABLE;
    endsequence

    a_off_shunt: assert property (
        (!drv_code && cd1_r == cd2_r) |-> SHUNT_ENABLE_OUT
            && !DRIVER_ENABLE_OUT && !BIG_CAP_SELECT)
        else $error("shunt or driver wrong for a disabled code");
    a_color_map: assert property (
        steady |-> COLOR_SELECT == hot(cd2_r))
        else $error("color select does not match the code");
    a_blank_map: assert property (
        steady |-> BLANK_SELECT == (!drv_code && cd2_r[3:2] != 2'h0))
        else $error("blank select does not match the code");
    a_bigcap_gate: assert property (
        BIG_CAP_SELECT |-> drv_code || cd1_r[1:0] != 2'h0)
        else $error("big cap select without a driver code");
    a_pulse_toggle: assert property (
        s_drv_fall |-> s_toggle)
        else $error("driver toggle or shunt wrong at pulse start");
    a_photo_end: assert property (
        s_lit_reach |=> SHUNT_ENABLE_OUT && !PHOTO_COMPARE_OUT)
        else $error("pulse not ended when threshold reached");
    a_compare_fall: assert property (
        $fell(PHOTO_COMPARE_OUT) |-> $past(PHOTO_REACHED) && SHUNT_ENABLE_OUT)
        else $error("compare output fell without a reached pulse");
    a_excess_src: assert property (
        $rose(EXCESS_BRIGHT) |-> $past(SEC_AMP_HB) != '0
            || $past(SEC_AMP_LB) != '0)
        else $error("excess flag rose with zero amplifier samples");
endmodule

bind led_group_select_brightness_monitor lgs_checker #(.AMP_W(AMP_W))
    lgs_checker_i (.*);

//--- verif/led_group_select_brightness_monitor_tb.sv
`timescale 1ns/1ns
`include "lgs_consts.svh"
module led_group_select_brightness_monitor_tb;
    typedef struct packed {
        logic [31:0] val;
        logic [31:0] msk;
    } note_t;
    localparam logic [31:0] ALL = 32'hFFFF_FFFF;
    logic        SYS_CLK = 1'b0;
    logic        ARST_N, AVS_READ, AVS_WRITE, PULSE_ENABLE, AVS_WAITREQUEST;
    logic [6:0]  AVS_ADDRESS;
    logic [31:0] AVS_WRITEDATA, AVS_READDATA;
    logic [3:0]  AVS_BYTEENABLE, LED_SELECT_CODE;
    logic [9:0]  SEC_AMP_HB, SEC_AMP_LB, PHOTO_THRESHOLD, thr;
    logic        SHUNT_REQUEST, PHOTO_REACHED, DRIVER_ENABLE_OUT, IRQ;
    logic        SHUNT_ENABLE_OUT, BLANK_SELECT, BIG_CAP_SELECT;
    logic        PHOTO_COMPARE_OUT, EXCESS_BRIGHT;
    logic [2:0]  COLOR_SELECT, PRIMARY_AMP_GAIN, g;
    logic [9:0]  tbl [16];
    note_t       rd_q [$];
    note_t       nt;
    int          n_fail = 0;
    int          samples_checked = 0;
    int          cycles = 0;
    int          lit;

    always #5 SYS_CLK = ~SYS_CLK;

    led_group_select_brightness_monitor
        led_group_select_brightness_monitor_i (.*);
    ctrl_model ctrl_model_i (.clk(SYS_CLK), .drv(DRIVER_ENABLE_OUT),
        .shunt(SHUNT_ENABLE_OUT), .req(SHUNT_REQUEST),
        .reached(PHOTO_REACHED));

    task automatic cmp(input string nm, input logic [31:0] e,
                       input logic [31:0] s);
        samples_checked++;
        if (s !== e) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic bus(input logic wr, input logic [6:0] a,
                       input logic [31:0] d);
        AVS_ADDRESS   <= a;
        AVS_WRITEDATA <= d;
        AVS_WRITE     <= wr;
        AVS_READ      <= !wr;
        @(posedge SYS_CLK);
        while (AVS_WAITREQUEST !== 1'b0)
            @(posedge SYS_CLK);
        AVS_WRITE <= 1'b0;
        AVS_READ  <= 1'b0;
        @(posedge SYS_CLK);
    endtask
    task automatic rd(input logic [6:0] a, input logic [31:0] e,
                      input logic [31:0] m);
        rd_q.push_back('{e & m, m});
        bus(1'b0, a, 32'h0);
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge SYS_CLK);
    endtask
    function automatic logic [2:0] hot(input logic [3:0] c);
        logic [1:0] k;
        k = (c[1:0] != 2'h0) ? c[1:0] : c[3:2];
        hot = (k == 2'h0) ? 3'h0 : 3'h1 << (k - 2'h1);
    endfunction

    // ============================================================
    // read watcher and run limit
    always @(posedge SYS_CLK) begin
        if (AVS_READ && AVS_WAITREQUEST === 1'b0) begin
            nt = rd_q.pop_front();
            cmp("readdata", nt.val, AVS_READDATA & nt.msk);
        end
        cycles++;
        if (cycles == 5000) begin
            n_fail++;
            finish_test();
        end
    end

    // ============================================================
    // main sequence
    initial begin
        ARST_N = 1'b0; AVS_READ = 1'b0; AVS_WRITE = 1'b0;
        AVS_ADDRESS = 7'h00; AVS_WRITEDATA = 32'h0; AVS_BYTEENABLE = 4'hF;
        LED_SELECT_CODE = 4'h0; PULSE_ENABLE = 1'b0;
        SEC_AMP_HB = 10'h000; SEC_AMP_LB = 10'h000;
        void'($urandom(32'h8B76));
        tick(2);
        ARST_N <= 1'b1;
        @(posedge SYS_CLK);
        rd(`OFS_CTRL, 32'h0, ALL);
        rd(`OFS_EXCESS_THR, 32'h3FF, ALL);
        rd(`OFS_PW_LIM_RED, 32'h100, ALL);
        rd(7'h3C, 32'h0, ALL);
        for (int i = 0; i < 16; i++) begin
            tbl[i] = 10'($urandom);
            bus(1'b1, `OFS_TABLE_BASE + 7'(4 * i), 32'(tbl[i]));
        end
        g = 3'($urandom);
        bus(1'b1, `OFS_CTRL, 32'(g) << `CTRL_GAIN_LO | 32'h2);
        cmp("gain", 32'(g), 32'(PRIMARY_AMP_GAIN));
        // continuous mode: big cap asked for but held off
        for (int i = 0; i < 16; i++) begin
            LED_SELECT_CODE <= 4'(i);
            tick(4);
            cmp("color", 32'(hot(4'(i))), 32'(COLOR_SELECT));
            cmp("blank", 32'(i[1:0] == 0 && i != 0), 32'(BLANK_SELECT));
            cmp("driver", 32'(i[1:0] != 0), 32'(DRIVER_ENABLE_OUT));
            cmp("shunt", 32'h1, 32'(SHUNT_ENABLE_OUT));
            cmp("bigcap", 32'h0, 32'(BIG_CAP_SELECT));
            if (i[1:0] != 0)
                cmp("thr", 32'(tbl[i]), 32'(PHOTO_THRESHOLD));
        end
        bus(1'b1, `OFS_IRQ_EN, 32'h2);
        bus(1'b1, `OFS_CTRL, 32'h3);
        PULSE_ENABLE    <= 1'b1;
        LED_SELECT_CODE <= 4'h6;
        tick(4);
        cmp("bigcap", 32'h1, 32'(BIG_CAP_SELECT));
        for (int d = 0; d < 12; d += 9) begin
            ctrl_model_i.pulse(d, lit);
            @(posedge SYS_CLK);
            cmp("compare", 32'h0, 32'(PHOTO_COMPARE_OUT));
            cmp("irq", 32'h1, 32'(IRQ));
            rd(`OFS_STATUS, 32'h2, 32'h2);
            bus(1'b1, `OFS_IRQ_CLR, 32'h2);
            cmp("irq", 32'h0, 32'(IRQ));
        end
        // no answer: width limit ends the pulse
        bus(1'b1, `OFS_IRQ_EN, 32'h0);
        bus(1'b1, `OFS_PW_LIM_GRN, 32'h6);
        ctrl_model_i.pulse(1000, lit);
        cmp("width", 32'h1, 32'(lit >= 6 && lit <= 9));
        cmp("compare", 32'h1, 32'(PHOTO_COMPARE_OUT));
        cmp("irq", 32'h0, 32'(IRQ));
        rd(`OFS_STATUS, 32'h4, 32'h4);
        bus(1'b1, `OFS_IRQ_EN, 32'h4);
        cmp("irq", 32'h1, 32'(IRQ));
        bus(1'b1, `OFS_IRQ_CLR, 32'h4);
        rd(`OFS_STATUS, 32'h0, 32'h4);
        PULSE_ENABLE <= 1'b0;
        thr = 10'($urandom_range(32'h3FE, 32'h1));
        bus(1'b1, `OFS_EXCESS_THR, 32'(thr));
        for (int k = 0; k < 4; k++) begin
            bus(1'b1, `OFS_CTRL, k[0] ? 32'hC : 32'h4);
            SEC_AMP_HB <= k[0] ? 10'h000 : thr + 10'(k[1]);
            SEC_AMP_LB <= k[0] ? thr + 10'(k[1]) : 10'h000;
            tick(3);
            cmp("excess", 32'(k[1]), 32'(EXCESS_BRIGHT));
        end
        rd(`OFS_STATUS, 32'h1, 32'h1);
        bus(1'b1, `OFS_EXCESS_THR, 32'(thr + 10'h1));
        tick(3);
        cmp("excess", 32'h0, 32'(EXCESS_BRIGHT));
        finish_test();
    end
endmodule
